// file: hw/psrst_map.vh
// Register map, field positions, reset values and timing counts of the
// peripheral soft reset block. Definitions only; included by bare name.
`ifndef PSRST_MAP_VH
`define PSRST_MAP_VH

// Register indices (word index; byte address is four times the index)
`define PSRST_IDX_DURATION      16'h1c04
`define PSRST_IDX_REQUEST       16'h1c05
`define PSRST_ADDR_DURATION     18'h07010
`define PSRST_ADDR_REQUEST      18'h07014
`define PSRST_ADDR_W            18

// Request register fields
`define PSRST_BIT_I2C           0
`define PSRST_BIT_GROUP_ONE     1
`define PSRST_BIT_CONVERTER     2
`define PSRST_BIT_USB           3
`define PSRST_BIT_DMA           4
`define PSRST_BIT_GROUP_THREE   5
`define PSRST_BIT_GROUP_FOUR    7
`define PSRST_REQ_MASK          8'hbf
`define PSRST_NUM_GROUPS        8

// Reset values
`define PSRST_DURATION_RST      16'h0008
`define PSRST_REQUEST_RST       8'h00

// Timing: least duration software should program, in cycles
`define PSRST_MIN_COUNT         16'h0008

// AXI responses
`define PSRST_RESP_OKAY         2'b00
`define PSRST_RESP_SLVERR       2'b10

`endif

// file: hw/psrst_axil.v
// AXI4-Lite slave front end: accepts one write and one read at a time,
// takes address and data in either order, answers with registered outputs.
// Assumes a single clock and that the core decodes the word address.
`timescale 1ns/1ps
`default_nettype none
`include "psrst_map.vh"

module psrst_axil #(
   parameter ADDR_W = `PSRST_ADDR_W
) (
   input  wire              clk_i,
   input  wire              rst_n_i,
   input  wire [ADDR_W-1:0] awaddr_i,
   input  wire              awvalid_i,
   output wire              awready_o,
   input  wire [31:0]       wdata_i,
   input  wire [3:0]        wstrb_i,
   input  wire              wvalid_i,
   output wire              wready_o,
   output reg  [1:0]        bresp_o,
   output reg               bvalid_o,
   input  wire              bready_i,
   input  wire [ADDR_W-1:0] araddr_i,
   input  wire              arvalid_i,
   output wire              arready_o,
   output reg  [31:0]       rdata_o,
   output reg  [1:0]        rresp_o,
   output reg               rvalid_o,
   input  wire              rready_i,
   output wire              wr_en_o,
   output wire [ADDR_W-1:0] wr_addr_o,
   output wire [31:0]       wr_data_o,
   output wire [3:0]        wr_strb_o,
   input  wire              wr_ok_i,
   output wire [ADDR_W-1:0] rd_addr_o,
   input  wire [31:0]       rd_data_i,
   input  wire              rd_ok_i
);

   reg              aw_have_q;
   reg [ADDR_W-1:0] aw_addr_q;
   reg              w_have_q;
   reg [31:0]       w_data_q;
   reg [3:0]        w_strb_q;

   // Each half is held until both are in and the response slot is free
   assign awready_o = !aw_have_q && !bvalid_o;
   assign wready_o  = !w_have_q && !bvalid_o;
   assign wr_en_o   = aw_have_q && w_have_q && !bvalid_o;
   assign wr_addr_o = aw_addr_q;
   assign wr_data_o = w_data_q;
   assign wr_strb_o = w_strb_q;

   // Write channel capture and response
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= {ADDR_W{1'b0}};
         w_have_q  <= 1'b0;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         bvalid_o  <= 1'b0;
         bresp_o   <= `PSRST_RESP_OKAY;
      end else begin
         if (awvalid_i && awready_o) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= awaddr_i;
         end
         if (wvalid_i && wready_o) begin
            w_have_q <= 1'b1;
            w_data_q <= wdata_i;
            w_strb_q <= wstrb_i;
         end
         if (wr_en_o) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_o  <= 1'b1;
            bresp_o   <= wr_ok_i ? `PSRST_RESP_OKAY : `PSRST_RESP_SLVERR;
         end else if (bvalid_o && bready_i) begin
            bvalid_o <= 1'b0;
         end
      end
   end

   // Read channel: one cycle from address to data
   assign arready_o = !rvalid_o;
   assign rd_addr_o = araddr_i;

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rvalid_o <= 1'b0;
         rdata_o  <= 32'h0000_0000;
         rresp_o  <= `PSRST_RESP_OKAY;
      end else if (arvalid_i && arready_o) begin
         rvalid_o <= 1'b1;
         rdata_o  <= rd_ok_i ? rd_data_i : 32'h0000_0000;
         rresp_o  <= rd_ok_i ? `PSRST_RESP_OKAY : `PSRST_RESP_SLVERR;
      end else if (rvalid_o && rready_i) begin
         rvalid_o <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// file: hw/psrst_counter.v
// Down counter for the reset hold time: loads a working copy of the
// programmed duration and steps it once per clock until it reaches zero.
// Assumes load is a one-cycle pulse from the register core.
`timescale 1ns/1ps
`default_nettype none

module psrst_counter #(
   parameter CNT_W = 16
) (
   input  wire             clk_i,
   input  wire             rst_n_i,
   input  wire             load_i,
   input  wire [CNT_W-1:0] value_i,
   output wire             busy_o,
   output wire             expire_o
);

   reg [CNT_W-1:0] cnt_q;
   reg             run_q;
   wire [CNT_W-1:0] cnt_d;

   // Working copy keeps the programmed value untouched for reuse
   assign cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
   assign busy_o = run_q;
   // Zero load expires at once; otherwise at the step that reaches zero
   assign expire_o = run_q && (cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1});

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= {CNT_W{1'b0}};
         run_q <= 1'b0;
      end else if (load_i) begin
         cnt_q <= value_i;
         run_q <= 1'b1;
      end else if (expire_o) begin
         cnt_q <= {CNT_W{1'b0}};
         run_q <= 1'b0;
      end else if (run_q) begin
         cnt_q <= cnt_d;
      end
   end

endmodule
`default_nettype wire

// file: hw/psrst_top.v
// Peripheral soft reset generator: software-programmed duration and
// per-group request bits drive active-low resets to peripheral groups.
// Assumes one system clock, AXI4-Lite register access, synchronous inputs.
//
// Operation
// - Writing one starts reset of that group
// - Hold selected resets low for programmed count, one cycle at count zero
// - Duration field is full 16 bits, any value
// - At zero count, clear all request bits
// - Request register reads show live reset state
// - One request bit resets several peripherals
// - Writing zero to request bit does nothing
// - Fixed bit map of groups to request bits
`timescale 1ns/1ps
`default_nettype none
`include "psrst_map.vh"

module psrst_top #(
   parameter ADDR_W = `PSRST_ADDR_W,
   parameter CNT_W  = 16
) (
   input  wire              CORE_CLK_I,
   input  wire              RST_N_I,
   input  wire [ADDR_W-1:0] S_AXI_AWADDR_I,
   input  wire              S_AXI_AWVALID_I,
   output wire              S_AXI_AWREADY_O,
   input  wire [31:0]       S_AXI_WDATA_I,
   input  wire [3:0]        S_AXI_WSTRB_I,
   input  wire              S_AXI_WVALID_I,
   output wire              S_AXI_WREADY_O,
   output wire [1:0]        S_AXI_BRESP_O,
   output wire              S_AXI_BVALID_O,
   input  wire              S_AXI_BREADY_I,
   input  wire [ADDR_W-1:0] S_AXI_ARADDR_I,
   input  wire              S_AXI_ARVALID_I,
   output wire              S_AXI_ARREADY_O,
   output wire [31:0]       S_AXI_RDATA_O,
   output wire [1:0]        S_AXI_RRESP_O,
   output wire              S_AXI_RVALID_O,
   input  wire              S_AXI_RREADY_I,
   output wire              I2C_RST_N_O,
   output wire              GROUP_ONE_RST_N_O,
   output wire              CONVERTER_RST_N_O,
   output wire              USB_RST_N_O,
   output wire              DMA_RST_N_O,
   output wire              GROUP_THREE_RST_N_O,
   output wire              GROUP_FOUR_RST_N_O,
   output wire              GROUP_FOUR_DISPLAY_RST_N_O,
   output wire              GROUP_FOUR_AUDIO0_RST_N_O,
   output wire              GROUP_FOUR_AUDIO1_RST_N_O,
   output wire              GROUP_FOUR_SERIAL_RST_N_O,
   output wire              GROUP_FOUR_SPI_RST_N_O,
   output wire              RESET_BUSY_O
);

   wire              wr_en;
   wire [ADDR_W-1:0] wr_addr;
   wire [31:0]       wr_data;
   wire [3:0]        wr_strb;
   wire              wr_ok;
   wire [ADDR_W-1:0] rd_addr;
   reg  [31:0]       rd_data;
   reg               rd_ok;

   reg  [CNT_W-1:0]  duration_q;
   reg  [7:0]        request_q;
   reg  [7:0]        request_d;
   reg  [7:0]        rst_n_q;
   wire              cnt_busy;
   wire              cnt_expire;
   wire              start;
   wire [7:0]        set_bits;
   wire              wr_dur;
   wire              wr_req;

   // Word indices at the width of the address slice they are compared with
   localparam [ADDR_W-3:0] IDX_DUR = `PSRST_IDX_DURATION;
   localparam [ADDR_W-3:0] IDX_REQ = `PSRST_IDX_REQUEST;

   // Bus front end
   psrst_axil #(
      .ADDR_W (ADDR_W)
   ) u_axil (
      .clk_i     (CORE_CLK_I),
      .rst_n_i   (RST_N_I),
      .awaddr_i  (S_AXI_AWADDR_I),
      .awvalid_i (S_AXI_AWVALID_I),
      .awready_o (S_AXI_AWREADY_O),
      .wdata_i   (S_AXI_WDATA_I),
      .wstrb_i   (S_AXI_WSTRB_I),
      .wvalid_i  (S_AXI_WVALID_I),
      .wready_o  (S_AXI_WREADY_O),
      .bresp_o   (S_AXI_BRESP_O),
      .bvalid_o  (S_AXI_BVALID_O),
      .bready_i  (S_AXI_BREADY_I),
      .araddr_i  (S_AXI_ARADDR_I),
      .arvalid_i (S_AXI_ARVALID_I),
      .arready_o (S_AXI_ARREADY_O),
      .rdata_o   (S_AXI_RDATA_O),
      .rresp_o   (S_AXI_RRESP_O),
      .rvalid_o  (S_AXI_RVALID_O),
      .rready_i  (S_AXI_RREADY_I),
      .wr_en_o   (wr_en),
      .wr_addr_o (wr_addr),
      .wr_data_o (wr_data),
      .wr_strb_o (wr_strb),
      .wr_ok_i   (wr_ok),
      .rd_addr_o (rd_addr),
      .rd_data_i (rd_data),
      .rd_ok_i   (rd_ok)
   );

   // Word decode on the register index; low two address bits ignored
   assign wr_dur = wr_en && (wr_addr[ADDR_W-1:2] == IDX_DUR);
   assign wr_req = wr_en && (wr_addr[ADDR_W-1:2] == IDX_REQ);
   assign wr_ok  = (wr_addr[ADDR_W-1:2] == IDX_DUR) ||
                   (wr_addr[ADDR_W-1:2] == IDX_REQ);

   // Only ones in the low byte count; zeros and reserved bits ignored
   assign set_bits = (wr_req && wr_strb[0]) ?
                     (wr_data[7:0] & `PSRST_REQ_MASK) : 8'h00;
   // A new request restarts the hold count for all active groups
   assign start = |set_bits;

   // Duration register, byte lanes honoured
   always @(posedge CORE_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         duration_q <= `PSRST_DURATION_RST;
      end else if (wr_dur) begin
         if (wr_strb[0]) begin
            duration_q[7:0] <= wr_data[7:0];
         end
         if (wr_strb[1]) begin
            duration_q[15:8] <= wr_data[15:8];
         end
      end
   end

   // Hold counter on a working copy
   psrst_counter #(
      .CNT_W (CNT_W)
   ) u_counter (
      .clk_i    (CORE_CLK_I),
      .rst_n_i  (RST_N_I),
      .load_i   (start),
      .value_i  (duration_q),
      .busy_o   (cnt_busy),
      .expire_o (cnt_expire)
   );

   // Request bits: a new set wins over an expiring count
   always @* begin
      request_d = request_q;
      if (cnt_expire) begin
         request_d = 8'h00;
      end
      request_d = request_d | set_bits;
   end

   always @(posedge CORE_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         request_q <= `PSRST_REQUEST_RST;
      end else begin
         request_q <= request_d;
      end
   end

   // Registered reset outputs, one per request bit
   genvar g;
   generate
      for (g = 0; g < `PSRST_NUM_GROUPS; g = g + 1) begin : gen_rst
         always @(posedge CORE_CLK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
               rst_n_q[g] <= 1'b1;
            end else begin
               rst_n_q[g] <= ~request_d[g];
            end
         end
      end
   endgenerate

   assign I2C_RST_N_O         = rst_n_q[`PSRST_BIT_I2C];
   assign GROUP_ONE_RST_N_O   = rst_n_q[`PSRST_BIT_GROUP_ONE];
   assign CONVERTER_RST_N_O   = rst_n_q[`PSRST_BIT_CONVERTER];
   assign USB_RST_N_O         = rst_n_q[`PSRST_BIT_USB];
   assign DMA_RST_N_O         = rst_n_q[`PSRST_BIT_DMA];
   assign GROUP_THREE_RST_N_O = rst_n_q[`PSRST_BIT_GROUP_THREE];
   assign GROUP_FOUR_RST_N_O  = rst_n_q[`PSRST_BIT_GROUP_FOUR];
   // Group four fans out to several peripherals from one bit
   assign GROUP_FOUR_DISPLAY_RST_N_O = rst_n_q[`PSRST_BIT_GROUP_FOUR];
   assign GROUP_FOUR_AUDIO0_RST_N_O  = rst_n_q[`PSRST_BIT_GROUP_FOUR];
   assign GROUP_FOUR_AUDIO1_RST_N_O  = rst_n_q[`PSRST_BIT_GROUP_FOUR];
   assign GROUP_FOUR_SERIAL_RST_N_O  = rst_n_q[`PSRST_BIT_GROUP_FOUR];
   assign GROUP_FOUR_SPI_RST_N_O     = rst_n_q[`PSRST_BIT_GROUP_FOUR];
   assign RESET_BUSY_O = cnt_busy;

   // Read mux; request read shows the driven reset state
   always @* begin
      rd_data = 32'h0000_0000;
      rd_ok   = 1'b1;
      if (rd_addr[ADDR_W-1:2] == IDX_DUR) begin
         rd_data[15:0] = duration_q;
      end else if (rd_addr[ADDR_W-1:2] == IDX_REQ) begin
         rd_data[7:0] = ~rst_n_q;
      end else begin
         rd_ok = 1'b0;
      end
   end

   // Software obligations on count and ordering are not enforced

endmodule
`default_nettype wire

// file: tb/psrst_periph.sv
// Peripheral stand-in that sits on a software reset line.
// Assumes the line is a registered active-low level on the system clock.
`timescale 1ns/1ps
`default_nettype none
module psrst_periph (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   output var  logic [15:0] low_len_o
);
   logic [15:0] cnt_q;
   // Length of the last low pulse, latched once the line lets go
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         cnt_q <= cnt_q + 16'h0001;
      end else if (cnt_q != 16'h0000) begin
         low_len_o <= cnt_q;
         cnt_q     <= 16'h0000;
      end
   end
   initial cnt_q = 16'h0000;
   initial low_len_o = 16'h0000;
endmodule
`default_nettype wire

// file: tb/psrst_top_sva.sv
// Checker for bus handshakes and reset outputs of the soft reset block.
// Assumes it is bound to psrst_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module psrst_top_sva (
   input wire logic        CORE_CLK_I,
   input wire logic        RST_N_I,
   input wire logic        S_AXI_AWREADY_O,
   input wire logic        S_AXI_BVALID_O,
   input wire logic        S_AXI_BREADY_I,
   input wire logic        S_AXI_ARVALID_I,
   input wire logic        S_AXI_ARREADY_O,
   input wire logic [31:0] S_AXI_RDATA_O,
   input wire logic        S_AXI_RVALID_O,
   input wire logic        S_AXI_RREADY_I,
   input wire logic        GROUP_FOUR_RST_N_O,
   input wire logic        GROUP_FOUR_DISPLAY_RST_N_O,
   input wire logic        I2C_RST_N_O,
   input wire logic        RESET_BUSY_O
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_N_I);
   // Reset lines against each other and against the hold counter
   chk_g4_copy: assert property (GROUP_FOUR_DISPLAY_RST_N_O == GROUP_FOUR_RST_N_O)
      else $error("group four copy differs");
   chk_idle_free: assert property (!RESET_BUSY_O |-> GROUP_FOUR_RST_N_O && I2C_RST_N_O)
      else $error("reset low while counter idle");
   chk_low_busy: assert property (!I2C_RST_N_O |-> RESET_BUSY_O)
      else $error("reset low without counter");
   // Bus answers stand until taken; a pending answer blocks new requests
   chk_r_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
      S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
      else $error("read answer dropped");
   chk_b_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O)
      else $error("write answer dropped");
   chk_ar_ready: assert property (S_AXI_ARREADY_O == !S_AXI_RVALID_O)
      else $error("read address ready wrong");
   chk_r_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
      else $error("read answer late");
   chk_b_excl: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O)
      else $error("write address ready while answer pending");
   cov_busy: cover property ($rose(RESET_BUSY_O));
   cov_g4: cover property ($fell(GROUP_FOUR_RST_N_O));
   cov_read: cover property (S_AXI_RVALID_O && S_AXI_RREADY_I);
endmodule
bind psrst_top psrst_top_sva u_sva (
   .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
   .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
   .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
   .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
   .S_AXI_RREADY_I(S_AXI_RREADY_I), .GROUP_FOUR_RST_N_O(GROUP_FOUR_RST_N_O),
   .GROUP_FOUR_DISPLAY_RST_N_O(GROUP_FOUR_DISPLAY_RST_N_O),
   .I2C_RST_N_O(I2C_RST_N_O), .RESET_BUSY_O(RESET_BUSY_O));
`default_nettype wire

// file: tb/peripheral_soft_reset_tb.sv
// Self-checking bench for the soft reset block over AXI4-Lite.
// Assumes design sources, checker and peripheral stand-in are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "psrst_map.vh"
module peripheral_soft_reset_tb;
   localparam AW = `PSRST_ADDR_W;
   localparam [AW-1:0] A_DUR = `PSRST_ADDR_DURATION;
   localparam [AW-1:0] A_REQ = `PSRST_ADDR_REQUEST;
   logic          clk = 1'b0;
   logic          rst_n = 1'b0;
   logic [AW-1:0] awaddr = 18'h00000;
   logic [AW-1:0] araddr = 18'h00000;
   logic          awvalid = 1'b0;
   logic          wvalid = 1'b0;
   logic          bready = 1'b0;
   logic          arvalid = 1'b0;
   logic          rready = 1'b0;
   logic [31:0]   wdata = 32'h0;
   logic [3:0]    wstrb = 4'hf;
   logic [31:0]   rdv;
   logic [1:0]    rrv;
   wire           awready, wready, bvalid, arready, rvalid, busy;
   wire  [1:0]    bresp, rresp;
   wire  [31:0]   rdata;
   wire  [7:0]    outs_n;
   wire  [4:0]    g4_n;
   wire  [15:0]   low_len;
   int            miscompares = 0;
   int            checks = 0;
   typedef struct { logic [7:0] req; logic [15:0] dur; logic [7:0] exp_n; } row_t;
   row_t rows [7] = '{'{8'h01, 16'h0008, 8'hfe}, '{8'h02, 16'h0009, 8'hfd},
      '{8'h04, 16'h000a, 8'hfb}, '{8'h08, 16'h0008, 8'hf7}, '{8'h10, 16'h000c, 8'hef},
      '{8'h20, 16'h0008, 8'hdf}, '{8'h80, 16'h0010, 8'h7f}};
   // Bit 6 has no group behind it
   assign outs_n[6] = 1'b1;
   psrst_top dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awaddr),
      .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
      .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
      .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
      .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
      .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
      .S_AXI_RREADY_I(rready), .I2C_RST_N_O(outs_n[0]), .GROUP_ONE_RST_N_O(outs_n[1]),
      .CONVERTER_RST_N_O(outs_n[2]), .USB_RST_N_O(outs_n[3]), .DMA_RST_N_O(outs_n[4]),
      .GROUP_THREE_RST_N_O(outs_n[5]), .GROUP_FOUR_RST_N_O(outs_n[7]),
      .GROUP_FOUR_DISPLAY_RST_N_O(g4_n[0]), .GROUP_FOUR_AUDIO0_RST_N_O(g4_n[1]),
      .GROUP_FOUR_AUDIO1_RST_N_O(g4_n[2]), .GROUP_FOUR_SERIAL_RST_N_O(g4_n[3]),
      .GROUP_FOUR_SPI_RST_N_O(g4_n[4]), .RESET_BUSY_O(busy));
   // Stand-in sees the line low whenever any group is held
   psrst_periph u_per (.clk_i(clk), .rst_n_i(&outs_n), .low_len_o(low_len));
   // Free-running system clock
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic hang;
      miscompares++;
      final_report();
   endtask
   // Write: address and data offered together, each released once taken
   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
      int i;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            chk_eq(bresp, er);
            break;
         end
      end
      if (i == 64) hang();
   endtask
   // Read: answer taken into rdv and rrv
   task automatic rd(input logic [AW-1:0] a);
      int i;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            rready <= 1'b0;
            rdv = rdata;
            rrv = rresp;
            break;
         end
      end
      if (i == 64) hang();
   endtask
   // Poll the request register until every group is out of reset
   task automatic wait_idle;
      int n;
      for (n = 0; n < 40; n++) begin
         rd(A_REQ);
         if (rdv === 32'h0) break;
      end
      if (n == 40) hang();
   endtask
   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk);
      hang();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(A_DUR);
      chk_eq(rdv, 32'h8);
      rd(A_REQ);
      chk_eq(rdv, 32'h0);
      foreach (rows[k]) begin
         wr(A_DUR, {16'h0, rows[k].dur}, `PSRST_RESP_OKAY);
         wr(A_REQ, {24'h0, rows[k].req}, `PSRST_RESP_OKAY);
         chk_eq(outs_n, rows[k].exp_n);
         chk_eq(busy, 1'b1);
         chk_eq(g4_n, {5{rows[k].exp_n[7]}});
         rd(A_REQ);
         chk_eq(rdv, rows[k].req);
         wait_idle();
         chk_eq(low_len, rows[k].dur);
         chk_eq(busy, 1'b0);
         chk_eq(outs_n, 8'hff);
         rd(A_DUR);
         chk_eq(rdv, rows[k].dur);
      end
      // Full-width duration field, both extremes
      wr(A_DUR, 32'hffff, `PSRST_RESP_OKAY);
      rd(A_DUR);
      chk_eq(rdv, 32'hffff);
      wr(A_DUR, 32'h0, `PSRST_RESP_OKAY);
      rd(A_DUR);
      chk_eq(rdv, 32'h0);
      // Upper byte lane alone: low byte and request bits stay untouched
      wstrb <= 4'h2;
      wr(A_DUR, 32'h1234, `PSRST_RESP_OKAY);
      wr(A_REQ, 32'hbf, `PSRST_RESP_OKAY);
      wstrb <= 4'hf;
      chk_eq(outs_n, 8'hff);
      rd(A_DUR);
      chk_eq(rdv, 32'h1200);
      // All groups at once, then a zero write mid-run must not disturb it
      wr(A_DUR, 32'h14, `PSRST_RESP_OKAY);
      wr(A_REQ, 32'hbf, `PSRST_RESP_OKAY);
      chk_eq(outs_n, 8'h40);
      wr(A_REQ, 32'h0, `PSRST_RESP_OKAY);
      chk_eq(outs_n, 8'h40);
      wait_idle();
      chk_eq(low_len, 32'h14);
      // Unmapped place is refused and reads as zero
      wr(18'h00000, 32'h1, `PSRST_RESP_SLVERR);
      rd(18'h00000);
      chk_eq(rrv, `PSRST_RESP_SLVERR);
      chk_eq(rdv, 32'h0);
      // Device reset in mid-run releases all groups
      wr(A_REQ, 32'h81, `PSRST_RESP_OKAY);
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      chk_eq(outs_n, 8'hff);
      chk_eq(busy, 1'b0);
      rst_n <= 1'b1;
      rd(A_DUR);
      chk_eq(rdv, 32'h8);
      rd(A_REQ);
      chk_eq(rdv, 32'h0);
      chk_eq(outs_n, 8'hff);
      final_report();
   end
endmodule
`default_nettype wire
